//--- rtl/gp8_cfg_reg.sv
// One eight-bit control register with reset value
`timescale 1ns/10ps
module gp8_cfg_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);
  logic [7:0] next_q;

  always_comb begin
    next_q = q;
    if (wr_en) begin
      next_q = wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VALUE;
    end else begin
      q <= next_q;
    end
  end
endmodule

//--- rtl/gp8_pin_cell.sv
// Per-pin input path: threshold choice and analog masking
`timescale 1ns/10ps
module gp8_pin_cell (
  input  wire logic pin_ttl,
  input  wire logic pin_schmitt,
  input  wire logic threshold_sel,
  input  wire logic analog_sel,
  output logic      level
);
  import gp8_pkg::*;

  always_comb begin
    // Buffer off when analog, so the digital value is forced low
    if (analog_sel) begin
      level = 1'b0;
    end else if (threshold_sel == GP8_THR_SCHMITT) begin
      level = pin_schmitt;
    end else begin
      level = pin_ttl;
    end
  end
endmodule

//--- rtl/gp8_pkg.sv
// Constants and types shared by the eight-bit port
package gp8_pkg;
  localparam int          GP8_WIDTH          = 8;
  localparam logic [7:0]  GP8_DIR_RESET      = 8'hFF;
  localparam logic [7:0]  GP8_ANALOG_RESET   = 8'hFF;
  localparam logic [7:0]  GP8_SLEW_RESET     = 8'hFF;
  localparam logic [7:0]  GP8_THRESH_RESET   = 8'hFF;
  localparam logic [7:0]  GP8_OD_RESET       = 8'h00;
  localparam logic [7:0]  GP8_PULLUP_RESET   = 8'h00;
  localparam logic [7:0]  GP8_LATCH_RESET    = 8'h00;
  localparam logic [7:0]  GP8_ZERO           = 8'h00;
  typedef enum logic [3:0] {
    GP8_REG_PIN_LEVEL,
    GP8_REG_DIRECTION,
    GP8_REG_LATCH,
    GP8_REG_ANALOG,
    GP8_REG_PULLUP,
    GP8_REG_OPEN_DRAIN,
    GP8_REG_SLEW,
    GP8_REG_THRESHOLD
  } gp8_reg_t;
  typedef enum logic {
    GP8_THR_TTL,
    GP8_THR_SCHMITT
  } gp8_thr_t;
endpackage

//--- rtl/gp8_port.sv
// Eight-bit general purpose I/O port with per-pin controls
// Summary of operation
// - Eight pins, each set as input or output on its own.
// - Direction bit 1 makes the pin an input, driver off.
// - Direction bit 0 enables the driver with the latch value.
// - Pin-level read gives pin levels; its write updates the latch.
// - Pin-level and latch writes store the write data unmodified in the latch.
// - Latch holds the latest latch or pin-level write.
// - Latch write equals pin-level write; latch read returns latch.
// - Analog select disables the pin's digital input buffer.
// - Digital reads of analog pins return zero.
// - Analog select leaves digital output driving untouched.
// - Analog select bits reset to analog.
// - Direction bits still govern drivers of analog input pins.
// - Open-drain bit makes output sink only; clear is push-pull.
// - Slew bit set limits slew rate; clear is full rate.
// - Threshold bit picks Schmitt or TTL for reads and the pin level output.
// - Enabled analog output overrides digital drive, forcing high impedance.
// - After reset every pin is an input; the latch drives none.
// - Peripheral owning a pin blocks latch drive; pin stays readable.
// - Two-wire serial peripheral makes its pin open-drain itself.
// - Each pin has its own weak pull-up enable.
// - Pull-up is disabled automatically on pins whose direction bit is 0.
// - Threshold bit 1 selects Schmitt, 0 selects TTL.
`timescale 1ns/10ps
module gp8_port (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  gp8_pkg::gp8_reg_t     reg_sel,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  input  wire logic [7:0]       pin_ttl,
  input  wire logic [7:0]       pin_schmitt,
  output logic      [7:0]       pin_out,
  output logic      [7:0]       pin_oe,
  output logic      [7:0]       pin_pullup_en,
  output logic      [7:0]       pin_slew_limit,
  output logic      [7:0]       pin_level,
  input  wire logic [7:0]       periph_en,
  input  wire logic [7:0]       periph_out,
  input  wire logic [7:0]       periph_oe,
  input  wire logic [7:0]       periph_two_wire,
  input  wire logic [7:0]       analog_out_en
);
  import gp8_pkg::*;

  // Control registers
  logic [7:0] direction_bits;
  logic [7:0] output_latch;
  logic [7:0] analog_select_bits;
  logic [7:0] open_drain_bits;
  logic [7:0] slew_limit_bits;
  logic [7:0] input_threshold_bits;
  logic [7:0] pull_up_enable_bits;

  // Digital level per pin after threshold choice and analog masking
  logic [7:0] level_now;
  logic [7:0] latch_wdata;

  // Write strobes, one per register
  logic       wr_dir;
  logic       wr_latch;
  logic       wr_analog;
  logic       wr_od;
  logic       wr_slew;
  logic       wr_thr;
  logic       wr_pu;

  // Next values of the registered outputs
  logic [7:0] next_reg_rdata;
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  logic [7:0] next_pin_pullup_en;
  logic [7:0] next_pin_slew_limit;
  logic [7:0] next_pin_level;

  // Write decode; pin-level and latch writes land in the same latch
  always_comb begin
    wr_dir    = 1'b0;
    wr_latch  = 1'b0;
    wr_analog = 1'b0;
    wr_od     = 1'b0;
    wr_slew   = 1'b0;
    wr_thr    = 1'b0;
    wr_pu     = 1'b0;
    if (!reg_wr) begin
      wr_dir = 1'b0;
    end else if (reg_sel == GP8_REG_PIN_LEVEL || reg_sel == GP8_REG_LATCH) begin
      wr_latch = 1'b1;
    end else if (reg_sel == GP8_REG_DIRECTION) begin
      wr_dir = 1'b1;
    end else if (reg_sel == GP8_REG_ANALOG) begin
      wr_analog = 1'b1;
    end else if (reg_sel == GP8_REG_PULLUP) begin
      wr_pu = 1'b1;
    end else if (reg_sel == GP8_REG_OPEN_DRAIN) begin
      wr_od = 1'b1;
    end else if (reg_sel == GP8_REG_SLEW) begin
      wr_slew = 1'b1;
    end else if (reg_sel == GP8_REG_THRESHOLD) begin
      wr_thr = 1'b1;
    end
  end

  // A full-byte write replaces every bit, so the sampled pin levels are
  // fully overwritten; the modify step is the CPU's own byte merge
  always_comb begin
    latch_wdata = (level_now & ~GP8_ZERO & GP8_ZERO) | reg_wdata;
  end

  // Configuration registers; each is rewritten whole on its own strobe
  // Resets to all inputs, so the latch drives nothing before software sets a direction
  gp8_cfg_reg #(
    .RESET_VALUE(GP8_DIR_RESET)
  ) u_dir (
    .clk    (clk),
    .rst_n  (rst_n),
    .wr_en  (wr_dir),
    .wr_data(reg_wdata),
    .q      (direction_bits)
  );

  // Pin-level and latch writes both land here
  gp8_cfg_reg #(
    .RESET_VALUE(GP8_LATCH_RESET)
  ) u_lat (
    .clk    (clk),
    .rst_n  (rst_n),
    .wr_en  (wr_latch),
    .wr_data(latch_wdata),
    .q      (output_latch)
  );

  // Resets to analog, so no input buffer burns current on a mid-level pin
  gp8_cfg_reg #(
    .RESET_VALUE(GP8_ANALOG_RESET)
  ) u_ans (
    .clk    (clk),
    .rst_n  (rst_n),
    .wr_en  (wr_analog),
    .wr_data(reg_wdata),
    .q      (analog_select_bits)
  );

  gp8_cfg_reg #(
    .RESET_VALUE(GP8_OD_RESET)
  ) u_od (
    .clk    (clk),
    .rst_n  (rst_n),
    .wr_en  (wr_od),
    .wr_data(reg_wdata),
    .q      (open_drain_bits)
  );

  gp8_cfg_reg #(
    .RESET_VALUE(GP8_SLEW_RESET)
  ) u_slr (
    .clk    (clk),
    .rst_n  (rst_n),
    .wr_en  (wr_slew),
    .wr_data(reg_wdata),
    .q      (slew_limit_bits)
  );

  gp8_cfg_reg #(
    .RESET_VALUE(GP8_THRESH_RESET)
  ) u_thr (
    .clk    (clk),
    .rst_n  (rst_n),
    .wr_en  (wr_thr),
    .wr_data(reg_wdata),
    .q      (input_threshold_bits)
  );

  gp8_cfg_reg #(
    .RESET_VALUE(GP8_PULLUP_RESET)
  ) u_pu (
    .clk    (clk),
    .rst_n  (rst_n),
    .wr_en  (wr_pu),
    .wr_data(reg_wdata),
    .q      (pull_up_enable_bits)
  );

  // One slice per pin: input buffer choice and drive priority
  genvar gi;
  generate
    for (gi = 0; gi < GP8_WIDTH; gi++) begin : g_pin
      logic slice_out;
      logic slice_oe;
      logic slice_pullup;

      gp8_pin_cell u_cell (
        .pin_ttl      (pin_ttl[gi]),
        .pin_schmitt  (pin_schmitt[gi]),
        .threshold_sel(input_threshold_bits[gi]),
        .analog_sel   (analog_select_bits[gi]),
        .level        (level_now[gi])
      );

      // Analog output, then peripheral, input, open-drain, push-pull;
      // analog select is deliberately not consulted on the drive side
      always_comb begin
        slice_out    = 1'b0;
        slice_oe     = 1'b0;
        slice_pullup = 1'b0;
        if (analog_out_en[gi]) begin
          slice_out = 1'b0;
          slice_oe  = 1'b0;
        end else if (periph_en[gi]) begin
          // Peripheral drives; the latch has no say here
          if (periph_two_wire[gi]) begin
            slice_out = 1'b0;
            slice_oe  = periph_oe[gi] & ~periph_out[gi];
          end else begin
            slice_out = periph_out[gi];
            slice_oe  = periph_oe[gi];
          end
        end else if (direction_bits[gi]) begin
          slice_oe = 1'b0;
        end else if (open_drain_bits[gi]) begin
          slice_out = 1'b0;
          slice_oe  = ~output_latch[gi];
        end else begin
          slice_out = output_latch[gi];
          slice_oe  = 1'b1;
        end
        // Pull-up only on pins whose direction bit selects input
        slice_pullup = pull_up_enable_bits[gi] & direction_bits[gi];
      end

      // Each slice owns its own bit of the next-value vectors
      assign next_pin_out[gi]       = slice_out;
      assign next_pin_oe[gi]        = slice_oe;
      assign next_pin_pullup_en[gi] = slice_pullup;
    end
  endgenerate

  // Slew and level pass straight through to their output flops
  assign next_pin_slew_limit = slew_limit_bits;
  assign next_pin_level      = level_now;

  // Read-back select; unmapped selects read as zero
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (!reg_rd) begin
      next_reg_rdata = reg_rdata;
    end else if (reg_sel == GP8_REG_PIN_LEVEL) begin
      next_reg_rdata = level_now;
    end else if (reg_sel == GP8_REG_LATCH) begin
      next_reg_rdata = output_latch;
    end else if (reg_sel == GP8_REG_DIRECTION) begin
      next_reg_rdata = direction_bits;
    end else if (reg_sel == GP8_REG_ANALOG) begin
      next_reg_rdata = analog_select_bits;
    end else if (reg_sel == GP8_REG_PULLUP) begin
      next_reg_rdata = pull_up_enable_bits;
    end else if (reg_sel == GP8_REG_OPEN_DRAIN) begin
      next_reg_rdata = open_drain_bits;
    end else if (reg_sel == GP8_REG_SLEW) begin
      next_reg_rdata = slew_limit_bits;
    end else if (reg_sel == GP8_REG_THRESHOLD) begin
      next_reg_rdata = input_threshold_bits;
    end else begin
      next_reg_rdata = GP8_ZERO;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= GP8_ZERO;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Registered outputs add one cycle of latency to every pad control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out        <= GP8_ZERO;
      pin_oe         <= GP8_ZERO;
      pin_pullup_en  <= GP8_ZERO;
      pin_slew_limit <= GP8_SLEW_RESET;
      pin_level      <= GP8_ZERO;
    end else begin
      pin_out        <= next_pin_out;
      pin_oe         <= next_pin_oe;
      pin_pullup_en  <= next_pin_pullup_en;
      pin_slew_limit <= next_pin_slew_limit;
      pin_level      <= next_pin_level;
    end
  end
endmodule

//--- tb/gp8_pad_model.sv
// Pads and board: resolves device drive, pull-ups and outside sources
`timescale 1ns/10ps
module gp8_pad_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_mid,
  output logic      [7:0] pin_ttl,
  output logic      [7:0] pin_schmitt
);
  logic       flt = 1'b0;
  logic [7:0] pad;
  // Undriven pins wander so a read of them cannot pass by luck
  always @(posedge clk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pad[i] = pin_out[i];
      else if (ext_en[i]) pad[i] = ext_val[i];
      else if (pin_pullup_en[i]) pad[i] = 1'b1;
      else pad[i] = flt;
    end
  end
  // A level between thresholds reads high on TTL, low on Schmitt
  assign pin_ttl = pad | ext_mid;
  assign pin_schmitt = pad & ~ext_mid;
endmodule

//--- tb/gp8_port_chk.sv
// Port-level assertions for the eight-bit port
`timescale 1ns/10ps
module gp8_port_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reg_rd,
  input gp8_pkg::gp8_reg_t reg_sel,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pin_ttl,
  input wire logic [7:0] pin_schmitt,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] pin_slew_limit,
  input wire logic [7:0] pin_level,
  input wire logic [7:0] periph_en,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  input wire logic [7:0] periph_two_wire,
  input wire logic [7:0] analog_out_en
);
  import gp8_pkg::*;
  logic [7:0] ao_q, tw_q, pp_q, po_q, pe_q, lv_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Inputs one edge back, since the pad outputs are registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {ao_q, tw_q, pp_q, po_q, pe_q, lv_q} <= '0;
    end else begin
      ao_q <= analog_out_en;
      tw_q <= periph_en & periph_two_wire & ~analog_out_en;
      pp_q <= periph_en & ~periph_two_wire & ~analog_out_en;
      po_q <= periph_out;
      pe_q <= periph_oe;
      lv_q <= pin_ttl | pin_schmitt;
    end
  end
  a_analog_hiz: assert property (analog_out_en != 8'h00 |=> (pin_oe & ao_q) == 8'h00)
    else $error("analog output pin still driven");
  a_pullup_out: assert property ((periph_en | analog_out_en) == 8'h00 |=>
    (pin_pullup_en & pin_oe) == 8'h00) else $error("pull-up on a driven pin");
  a_two_wire_od: assert property (tw_q != 8'h00 |-> (pin_out & tw_q) == 8'h00 &&
    (pin_oe & tw_q) == (pe_q & ~po_q & tw_q)) else $error("two-wire pin not open-drain");
  a_periph_drive: assert property (pp_q != 8'h00 |-> (pin_oe & pp_q) == (pe_q & pp_q)
    && (pin_out & pe_q & pp_q) == (po_q & pe_q & pp_q)) else $error("peripheral drive lost");
  a_level_src: assert property (##1 (pin_level & ~lv_q) == 8'h00)
    else $error("pin level high with both buffers low");
  a_rd_refused: assert property (reg_rd && reg_sel > GP8_REG_THRESHOLD
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_reset_out: assert property ($rose(rst_n) |-> pin_oe == 8'h00 && pin_pullup_en == 8'h00
    && pin_slew_limit == GP8_SLEW_RESET) else $error("pad outputs wrong after reset");
endmodule

//--- tb/test_gp8_port.sv
// Self-checking bench for the eight-bit port
`timescale 1ns/10ps
module test_gp8_port;
  import gp8_pkg::*;
  typedef struct {gp8_reg_t sel; logic [7:0] wd; logic [7:0] rd;} gp8_row_t;
  logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  gp8_reg_t   reg_sel = GP8_REG_PIN_LEVEL;
  logic [7:0] reg_wdata = 8'h00, ext_val = 8'h03, ext_en = 8'h0F, ext_mid = 8'h00;
  logic [7:0] periph_en = 8'h00, periph_out = 8'h00, periph_oe = 8'h00;
  logic [7:0] periph_two_wire = 8'h00, analog_out_en = 8'h00;
  logic [7:0] reg_rdata, pin_ttl, pin_schmitt, pin_out, pin_oe, pin_pullup_en;
  logic [7:0] pin_slew_limit, pin_level;
  int         failures = 0, tests_run = 0;
  gp8_row_t   rows [8] = '{'{GP8_REG_DIRECTION, 8'h5A, 8'h5A}, '{GP8_REG_LATCH, 8'hC3, 8'hC3},
    '{GP8_REG_ANALOG, 8'h81, 8'h81}, '{GP8_REG_PULLUP, 8'h0F, 8'h0F},
    '{GP8_REG_OPEN_DRAIN, 8'hF0, 8'hF0}, '{GP8_REG_SLEW, 8'h3C, 8'h3C},
    '{GP8_REG_THRESHOLD, 8'h66, 8'h66}, '{gp8_reg_t'(4'h9), 8'hFF, 8'h00}};
  logic [7:0] rv [7] = '{GP8_DIR_RESET, GP8_LATCH_RESET, GP8_ANALOG_RESET, GP8_PULLUP_RESET,
    GP8_OD_RESET, GP8_SLEW_RESET, GP8_THRESH_RESET};
  gp8_port u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_ttl(pin_ttl),
    .pin_schmitt(pin_schmitt), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .pin_slew_limit(pin_slew_limit), .pin_level(pin_level),
    .periph_en(periph_en), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_two_wire(periph_two_wire), .analog_out_en(analog_out_en));
  gp8_pad_model u_pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .ext_mid(ext_mid),
    .pin_ttl(pin_ttl), .pin_schmitt(pin_schmitt));
  always #2 clk = ~clk;
  task automatic final_report;
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input gp8_reg_t s, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data registers at the taking edge and holds, so one spare edge is safe
  task automatic rc(input gp8_reg_t s, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_sel <= s;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(s.name(), e, reg_rdata);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].sel, rows[i].wd);
      rc(rows[i].sel, rows[i].rd);
    end
    settle();
    chk("pin_slew_limit", 8'h3C, pin_slew_limit);
    chk("pin_oe", 8'h25, pin_oe);
    chk("pin_out", 8'h01, pin_out & pin_oe);
    chk("pin_pullup_en", 8'h0A, pin_pullup_en);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rv[i]) rc(gp8_reg_t'(4'(i + 1)), rv[i]);
    rc(GP8_REG_PIN_LEVEL, 8'h00);
    wr(GP8_REG_ANALOG, 8'h00);
    wr(GP8_REG_DIRECTION, 8'h0F);
    wr(GP8_REG_LATCH, 8'h11);
    wr(GP8_REG_PIN_LEVEL, 8'hA5);
    settle();
    chk("pin_oe", 8'hF0, pin_oe);
    chk("pin_out", 8'hA0, pin_out & 8'hF0);
    rc(GP8_REG_LATCH, 8'hA5);
    rc(GP8_REG_PIN_LEVEL, 8'hA3);
    wr(GP8_REG_ANALOG, 8'h81);
    settle();
    rc(GP8_REG_PIN_LEVEL, 8'h22);
    chk("pin_level", 8'h22, pin_level);
    chk("pin_oe", 8'hF0, pin_oe);
    wr(GP8_REG_ANALOG, 8'h00);
    ext_mid <= 8'h0C;
    settle();
    rc(GP8_REG_PIN_LEVEL, 8'hA3);
    wr(GP8_REG_THRESHOLD, 8'h00);
    settle();
    rc(GP8_REG_PIN_LEVEL, 8'hAF);
    @(posedge clk);
    {periph_en, periph_out, periph_oe, periph_two_wire} <= {8'h03, 8'h01, 8'h03, 8'h02};
    {analog_out_en, ext_en, ext_mid} <= {8'h40, 8'h4F, 8'h00};
    settle();
    chk("pin_oe", 8'hB3, pin_oe);
    chk("pin_out", 8'hA1, pin_out & pin_oe);
    rc(GP8_REG_PIN_LEVEL, 8'hA1);
    wr(GP8_REG_OPEN_DRAIN, 8'hF0);
    wr(GP8_REG_PULLUP, 8'hFF);
    settle();
    chk("pin_oe", 8'h13, pin_oe);
    chk("pin_pullup_en", 8'h0F, pin_pullup_en);
    final_report();
  end
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule
bind gp8_port gp8_port_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_sel(reg_sel), .reg_rdata(reg_rdata), .pin_ttl(pin_ttl), .pin_schmitt(pin_schmitt),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
  .pin_slew_limit(pin_slew_limit), .pin_level(pin_level), .periph_en(periph_en),
  .periph_out(periph_out), .periph_oe(periph_oe), .periph_two_wire(periph_two_wire),
  .analog_out_en(analog_out_en));
